// ---- verilog/ectc_pkg.sv ----
/*
 * ectc_pkg: register map, field positions, reset values and shared types of
 * the 16-bit event counter / capture timer channel.
 * Assumes a 32-bit classic Wishbone slave port, one aligned word per register.
 */
// How it works
// R1: second compare match raises second interrupt unless stopped or second register captures
// R2: software configures everything before run mode 11
// R3: run mode 00 clears counter, stops
// R4: clock select 11 counts first input edges
// R5: no event counting while run mode 10
// R6: first match after M+2 edges, then M+1
// R7: edge valid after two equal consecutive samples
// R8: edge select 00 fall, 01 rise, 11 both
// R9: output enable gates pin; level bits preset flop
// R10: toggle select: none, first, second, either match
// R11: capture bits clear: first register compares
// R12: event count M+1 raises first match interrupt
// R13: software never loads first register with zero
// R14: second match in event counting keeps counter
// R15: run mode 10 counts, first edge clears
// R16: without edges counter wraps, keeps counting
// R17: edge-cleared mode counts immediately on entry
// R18: compare registers match raise their interrupts
// R19: second input or reverse phase captures first
// R20: first input edge captures second, clears counter
// R21: software avoids clock select 11 in mode 10
// R22: reverse-phase capture raises no first interrupt
// R23: counter wrap sets overflow flag, software clears
package ectc_pkg;

	localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CAPCMP_CTRL = 8'h04;
	localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PRESCALER = 8'h0c;
	localparam logic [7:0] ADDR_COUNT_SRC = 8'h10;
	localparam logic [7:0] ADDR_COUNT_VALUE = 8'h14;
	localparam logic [7:0] ADDR_CAPCMP_FIRST = 8'h18;
	localparam logic [7:0] ADDR_CAPCMP_SECOND = 8'h1c;

	// timer_mode_control fields
	localparam int MC_OVERFLOW = 0;
	localparam int MC_TOGGLE_CLEAR = 1;
	localparam int MC_RUN_LO = 2;
	// capture_compare_control fields
	localparam int CC_SEL_FIRST = 0;
	localparam int CC_PHASE = 1;
	localparam int CC_SEL_SECOND = 2;
	// timer_output_control fields
	localparam int OC_ENABLE = 0;
	localparam int OC_TOGGLE_FIRST = 1;
	localparam int OC_LEVEL_RESET = 2;
	localparam int OC_LEVEL_SET = 3;
	localparam int OC_TOGGLE_SECOND = 4;
	// prescaler_mode fields
	localparam int PM_CLOCK_LO = 0;
	localparam int PM_EDGE_FIRST_LO = 4;
	localparam int PM_EDGE_SECOND_LO = 6;
	// count_source_select fields
	localparam int CS_TABLE = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_EDGE_CLEAR = 2'h2;
	localparam logic [1:0] RUN_MATCH_CLEAR = 2'h3;
	localparam logic [1:0] CLK_EVENT = 2'h3;
	localparam logic [1:0] CLK_AUX = 2'h2;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	typedef enum logic [3:0] {
		ST_STOP = 4'b0001,
		ST_FREE = 4'b0010,
		ST_EDGE = 4'b0100,
		ST_MATCH = 4'b1000
	} ectc_state_type;

	typedef struct packed {
		logic toggle_on_clear_sel;
		logic [1:0] run_mode;
		logic overflow_flag;
	} ectc_mode_type;

	typedef struct packed {
		logic [1:0] edge_sel_second;
		logic [1:0] edge_sel_first;
		logic [1:0] clock_sel;
	} ectc_presc_type;

endpackage : ectc_pkg

// ---- verilog/ectc_top.sv ----
/*
 * ectc_top: one 16-bit timer / event counter channel with two
 * capture-compare registers, filtered event inputs and a toggle output.
 * Assumes event inputs already synchronous to clk_sys_i and a classic
 * Wishbone master; aux_tick_i is a one-cycle pulse from a slow time base.
 */
`timescale 1ns/100ps
`default_nettype none
module ectc_top
	import ectc_pkg::*;
#(
	parameter int DATA_WIDTH = 16
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic event_in_first_i,
	input wire logic event_in_second_i,
	input wire logic aux_tick_i,
	output logic toggle_out_pin_o,
	output logic match_irq_first_o,
	output logic match_irq_second_o
);

	ectc_mode_type mode;
	ectc_presc_type presc;
	ectc_state_type state;
	logic [2:0] capcmp_ctrl;
	logic [4:0] out_ctrl;
	logic clock_table_sel;
	logic [DATA_WIDTH-1:0] count_value;
	logic [DATA_WIDTH-1:0] capcmp_first;
	logic [DATA_WIDTH-1:0] capcmp_second;
	logic [3:0] presc_cnt;
	logic [1:0] samp_first;
	logic [1:0] samp_second;
	logic level_first;
	logic level_second;
	logic armed;
	logic toggle_ff;

	// edge select decode, shared by both event inputs
	function automatic logic edge_hit(input logic [1:0] esel, input logic old_lvl,
			input logic new_lvl);
		logic rise;
		logic fall;
		rise = ~old_lvl & new_lvl;
		fall = old_lvl & ~new_lvl;
		case (esel)
			EDGE_FALL: edge_hit = fall;
			EDGE_RISE: edge_hit = rise;
			EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// write strobe for one register address
	function automatic logic wr_hit(input logic strobe, input logic [7:0] adr,
			input logic [7:0] reg_adr);
		wr_hit = strobe & (adr == reg_adr);
	endfunction : wr_hit

	// bus access
	logic bus_req;
	logic bus_wr;
	logic bus_wr_lo;
	logic bus_wr_hi;
	logic wr_mode;
	logic wr_capcmp_ctrl;
	logic wr_out;
	logic wr_presc;
	logic wr_src;
	logic wr_first_lo;
	logic wr_first_hi;
	logic wr_second_lo;
	logic wr_second_hi;
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i;
	assign bus_wr_lo = bus_wr & wb_sel_i[0];
	assign bus_wr_hi = bus_wr & wb_sel_i[1];
	assign wr_mode = wr_hit(bus_wr_lo, wb_adr_i, ADDR_MODE_CTRL);
	assign wr_capcmp_ctrl = wr_hit(bus_wr_lo, wb_adr_i, ADDR_CAPCMP_CTRL);
	assign wr_out = wr_hit(bus_wr_lo, wb_adr_i, ADDR_OUT_CTRL);
	assign wr_presc = wr_hit(bus_wr_lo, wb_adr_i, ADDR_PRESCALER);
	assign wr_src = wr_hit(bus_wr_lo, wb_adr_i, ADDR_COUNT_SRC);
	assign wr_first_lo = wr_hit(bus_wr_lo, wb_adr_i, ADDR_CAPCMP_FIRST);
	assign wr_first_hi = wr_hit(bus_wr_hi, wb_adr_i, ADDR_CAPCMP_FIRST);
	assign wr_second_lo = wr_hit(bus_wr_lo, wb_adr_i, ADDR_CAPCMP_SECOND);
	assign wr_second_hi = wr_hit(bus_wr_hi, wb_adr_i, ADDR_CAPCMP_SECOND);

	// input filter: a level is accepted only after two equal samples
	logic filt_first;
	logic filt_second;
	logic edge_first;
	logic edge_first_rev;
	logic edge_second;
	assign filt_first = (samp_first[0] == samp_first[1]) ? samp_first[1] : level_first; // R7
	assign filt_second = (samp_second[0] == samp_second[1]) ? samp_second[1] : level_second;
	assign edge_first = edge_hit(presc.edge_sel_first, level_first, filt_first); // R8
	assign edge_first_rev = edge_hit(presc.edge_sel_first, ~level_first, ~filt_first);
	assign edge_second = edge_hit(presc.edge_sel_second, level_second, filt_second);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			samp_first <= 2'h0;
			samp_second <= 2'h0;
			level_first <= 1'b0;
			level_second <= 1'b0;
		end else begin
			samp_first <= {samp_first[0], event_in_first_i};
			samp_second <= {samp_second[0], event_in_second_i};
			level_first <= filt_first;
			level_second <= filt_second;
		end
	end

	// count clock selection; the divider runs free so ticks stay evenly spaced
	logic count_tick;
	always_comb begin
		count_tick = 1'b0;
		case (presc.clock_sel)
			2'h0: count_tick = clock_table_sel ? presc_cnt[0] : 1'b1;
			2'h1: count_tick = clock_table_sel ? (presc_cnt[2:0] == 3'h7)
				: (presc_cnt[1:0] == 2'h3);
			CLK_AUX: count_tick = clock_table_sel ? (presc_cnt == 4'hf) : aux_tick_i;
			CLK_EVENT: count_tick = edge_first; // R4
			default: count_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			presc_cnt <= 4'h0;
		end else begin
			presc_cnt <= presc_cnt + 4'h1;
		end
	end

	// run state follows the mode field
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= ST_STOP;
		end else begin
			case (mode.run_mode)
				RUN_STOP: state <= ST_STOP;
				RUN_EDGE_CLEAR: state <= ST_EDGE;
				RUN_MATCH_CLEAR: state <= ST_MATCH;
				default: state <= ST_FREE;
			endcase
		end
	end

	// match and capture events
	logic cmp_first_en;
	logic cmp_second_en;
	logic match_first;
	logic match_second;
	logic edge_clear;
	logic cap_first;
	logic cap_first_irq;
	logic cap_second;
	logic wrap;
	logic stopped;
	assign stopped = (state == ST_STOP);
	assign cmp_first_en = ~capcmp_ctrl[CC_SEL_FIRST]; // R11
	assign cmp_second_en = ~capcmp_ctrl[CC_SEL_SECOND];
	assign match_first = ~stopped & count_tick & cmp_first_en
		& (count_value == capcmp_first) & ~(state == ST_MATCH & armed); // R4 R12 R18
	assign match_second = ~stopped & count_tick & cmp_second_en
		& (count_value == capcmp_second) & ~(state == ST_MATCH & armed); // R1 R14 R18
	assign edge_clear = (state == ST_EDGE) & edge_first; // R15
	assign cap_second = edge_clear & capcmp_ctrl[CC_SEL_SECOND]; // R20
	assign cap_first = (state == ST_EDGE) & capcmp_ctrl[CC_SEL_FIRST]
		& (edge_second | (capcmp_ctrl[CC_PHASE] & edge_first_rev)); // R19
	assign cap_first_irq = cap_first & edge_second; // R22
	assign wrap = count_tick & ~edge_clear & (count_value == COUNT_MAX)
		& (state == ST_EDGE | state == ST_FREE); // R16

	// counter; first tick after entering match-clear mode from stop only loads zero and clears armed
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			count_value <= RESET_WORD;
			armed <= 1'b0;
		end else begin
			case (state)
				ST_STOP: begin
					count_value <= RESET_WORD; // R3
					armed <= 1'b1;
				end
				ST_MATCH: begin
					if (count_tick) begin
						armed <= 1'b0;
						if (armed) begin
							count_value <= RESET_WORD; // R6
						end else if (count_value == capcmp_first) begin
							count_value <= RESET_WORD; // R6
						end else begin
							count_value <= count_value + 16'h1; // R14
						end
					end
				end
				ST_EDGE: begin
					armed <= 1'b0;
					if (edge_clear) begin
						count_value <= RESET_WORD; // R15 R20 R21
					end else if (count_tick) begin
						count_value <= count_value + 16'h1; // R17
					end
				end
				ST_FREE: begin
					armed <= 1'b0;
					if (count_tick) begin
						count_value <= count_value + 16'h1;
					end
				end
				default: begin
					count_value <= RESET_WORD;
					armed <= 1'b0;
				end
			endcase
		end
	end

	// interrupt request pulses
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			match_irq_first_o <= 1'b0;
		end else begin
			match_irq_first_o <= match_first | cap_first_irq; // R19 R22
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			match_irq_second_o <= 1'b0;
		end else begin
			match_irq_second_o <= match_second | cap_second; // R20
		end
	end

	// mode control; hardware overflow set wins over a software clear
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			mode <= ectc_mode_type'(4'h0);
		end else begin
			if (wr_mode) begin
				mode.run_mode <= wb_dat_i[MC_RUN_LO+1:MC_RUN_LO];
				mode.toggle_on_clear_sel <= wb_dat_i[MC_TOGGLE_CLEAR];
				mode.overflow_flag <= wb_dat_i[MC_OVERFLOW] & mode.overflow_flag;
			end
			if (wrap) begin
				mode.overflow_flag <= 1'b1; // R23
			end
		end
	end

	// remaining control registers, one block each
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			capcmp_ctrl <= RESET_BYTE[2:0];
		end else if (wr_capcmp_ctrl) begin
			capcmp_ctrl <= wb_dat_i[2:0];
		end
	end

	// level bits act as strobes and are not stored
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			out_ctrl <= RESET_BYTE[4:0];
		end else if (wr_out) begin
			out_ctrl <= {wb_dat_i[OC_TOGGLE_SECOND], 2'h0, wb_dat_i[OC_TOGGLE_FIRST],
				wb_dat_i[OC_ENABLE]};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			presc <= ectc_presc_type'(RESET_BYTE[5:0]);
		end else if (wr_presc) begin
			presc <= ectc_presc_type'(wb_dat_i[7:2] & 6'h3c
				| {4'h0, wb_dat_i[PM_CLOCK_LO+1:PM_CLOCK_LO]});
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			clock_table_sel <= 1'b0;
		end else if (wr_src) begin
			clock_table_sel <= wb_dat_i[CS_TABLE];
		end
	end

	// capture-compare registers; a capture wins over a same-cycle write
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			capcmp_first <= RESET_WORD;
		end else if (cap_first) begin
			capcmp_first <= count_value; // R19
		end else begin
			if (wr_first_lo) begin
				capcmp_first[7:0] <= wb_dat_i[7:0];
			end
			if (wr_first_hi) begin
				capcmp_first[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			capcmp_second <= RESET_WORD;
		end else if (cap_second) begin
			capcmp_second <= count_value; // R20
		end else begin
			if (wr_second_lo) begin
				capcmp_second[7:0] <= wb_dat_i[7:0];
			end
			if (wr_second_hi) begin
				capcmp_second[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// toggle flop and pin
	logic do_toggle;
	assign do_toggle = (match_first & out_ctrl[OC_TOGGLE_FIRST])
		| (match_second & out_ctrl[OC_TOGGLE_SECOND])
		| (edge_clear & mode.toggle_on_clear_sel); // R10
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			toggle_ff <= 1'b0;
		end else if (wr_out && wb_dat_i[OC_LEVEL_SET]) begin
			toggle_ff <= 1'b1; // R9
		end else if (wr_out && wb_dat_i[OC_LEVEL_RESET]) begin
			toggle_ff <= 1'b0; // R9
		end else if (do_toggle) begin
			toggle_ff <= ~toggle_ff;
		end
	end

	// gated copy keeps the pin straight off a flop
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			toggle_out_pin_o <= 1'b0;
		end else begin
			toggle_out_pin_o <= out_ctrl[OC_ENABLE] & toggle_ff; // R9
		end
	end

	// bus answer: one wait state, unmapped reads return zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0;
		case (wb_adr_i)
			ADDR_MODE_CTRL: rd_data = {28'h0, mode.run_mode, mode.toggle_on_clear_sel,
				mode.overflow_flag};
			ADDR_CAPCMP_CTRL: rd_data = {29'h0, capcmp_ctrl};
			ADDR_OUT_CTRL: rd_data = {27'h0, out_ctrl[4], 2'h0, out_ctrl[1:0]};
			ADDR_PRESCALER: rd_data = {24'h0, presc.edge_sel_second, presc.edge_sel_first,
				2'h0, presc.clock_sel};
			ADDR_COUNT_SRC: rd_data = {31'h0, clock_table_sel};
			ADDR_COUNT_VALUE: rd_data = {16'h0, count_value};
			ADDR_CAPCMP_FIRST: rd_data = {16'h0, capcmp_first};
			ADDR_CAPCMP_SECOND: rd_data = {16'h0, capcmp_second};
			default: rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h0;
		end
	end

endmodule : ectc_top
`default_nettype wire

// ---- dv/ectc_top_properties.sv ----
/* ectc_top_properties: port-level checker for ectc_top.
 * Assumes it is bound to ectc_top and that software writes use lane 0. */
`timescale 1ns/100ps
`default_nettype none
module ectc_checker
	import ectc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic toggle_out_pin_o,
	input wire logic match_irq_first_o,
	input wire logic match_irq_second_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	logic wr;
	logic wr_d1, wr_d2, en, tog, clr;
	logic [1:0] run, stop_cnt;
	// shadow follows the ack edge, one cycle behind the design
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			{wr_d1, wr_d2, en, tog, clr, run} <= '0;
		end else begin
			{wr_d1, wr_d2} <= {wr, wr_d1};
			if (wr && wb_adr_i == ADDR_OUT_CTRL) begin
				en <= wb_dat_i[OC_ENABLE];
				tog <= wb_dat_i[OC_TOGGLE_FIRST] | wb_dat_i[OC_TOGGLE_SECOND];
			end
			if (wr && wb_adr_i == ADDR_MODE_CTRL) begin
				clr <= wb_dat_i[MC_TOGGLE_CLEAR];
				run <= wb_dat_i[3:2];
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || wr || run != RUN_STOP) begin
			stop_cnt <= 2'h0;
		end else if (stop_cnt != 2'h3) begin
			stop_cnt <= stop_cnt + 2'h1;
		end
	end
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked in one cycle");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
	property p_irq1_pulse; $rose(match_irq_first_o) |=> !match_irq_first_o; endproperty
	a_irq1_pulse: assert property (p_irq1_pulse) else $error("first irq wider than a pulse");
	property p_irq2_pulse; match_irq_second_o ##1 1'b1 |-> !match_irq_second_o; endproperty
	a_irq2_pulse: assert property (p_irq2_pulse) else $error("second irq wider than a pulse");
	property p_pin_off; !en && !wr && !wr_d1 |-> !toggle_out_pin_o; endproperty
	a_pin_off: assert property (p_pin_off) else $error("toggle pin high while disabled");
	property p_toggle_none; $changed(toggle_out_pin_o) |-> tog || clr || wr || wr_d1 || wr_d2;
	endproperty
	a_toggle_none: assert property (p_toggle_none) else $error("pin toggled with none selected");
	property p_irq_stop; stop_cnt == 2'h3 |-> !(match_irq_first_o || match_irq_second_o);
	endproperty
	a_irq_stop: assert property (p_irq_stop) else $error("irq while counter stopped");
endmodule : ectc_checker
bind ectc_top ectc_checker ectc_checker_i (.clk_sys_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .toggle_out_pin_o,
	.match_irq_first_o, .match_irq_second_o);
`default_nettype wire

// ---- dv/ectc_event_model.sv ----
/* ectc_event_model: drives the two event pins and a slow time base.
 * Assumes the bench requests one pulse at a time, after the last has ended. */
`timescale 1ns/100ps
`default_nettype none
module ectc_event_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic go_i,
	input wire logic pin_i,
	input wire logic idle_i,
	input wire logic [3:0] width_i,
	output logic event_in_first_o,
	output logic event_in_second_o,
	output logic aux_tick_o
);
	logic [3:0] left;
	logic [2:0] div;
	logic sel;
	// a width of one is a glitch the filter has to reject
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			left <= 4'h0;
			sel <= 1'b0;
		end else if (go_i) begin
			left <= width_i;
			sel <= pin_i;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		div <= (reset_i || div == 3'h4) ? 3'h0 : div + 3'h1;
		aux_tick_o <= !reset_i && div == 3'h4;
	end
	assign event_in_first_o = idle_i ^ (left != 4'h0 && !sel);
	assign event_in_second_o = left != 4'h0 && sel;
endmodule : ectc_event_model
`default_nettype wire

// ---- dv/ectc_top_tb_top.sv ----
/* ectc_top_tb_top: self-checking bench for ectc_top over classic wishbone.
 * Assumes the event model on the pins and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module ectc_top_tb_top
	import ectc_pkg::*;
;
	logic clk_sys_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, go = 0, pin = 0, idle = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, d;
	logic [3:0] width = 0;
	logic ack, tog_o, irq1, irq2, ev1, ev2, aux, pin_q;
	int n_mismatch = 0, n_compared = 0, n1 = 0, n2 = 0, ntog = 0, s1, s2, st, i, cycles = 0;
	logic [1:0] es [3] = '{2'h0, 2'h1, 2'h3};
	logic [15:0] ec [3] = '{16'h2, 16'h3, 16'h6};
	always #5 clk_sys_i = ~clk_sys_i;
	ectc_top ectc_top_i (.clk_sys_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.event_in_first_i(ev1), .event_in_second_i(ev2), .aux_tick_i(aux),
		.toggle_out_pin_o(tog_o), .match_irq_first_o(irq1), .match_irq_second_o(irq2));
	ectc_event_model ectc_event_model_i (.clk_sys_i, .reset_i, .go_i(go), .pin_i(pin),
		.idle_i(idle), .width_i(width), .event_in_first_o(ev1), .event_in_second_o(ev2),
		.aux_tick_o(aux));
	always @(posedge clk_sys_i) begin
		pin_q <= tog_o;
		if (!reset_i) begin
			n1 <= n1 + (irq1 === 1'b1);
			n2 <= n2 + (irq2 === 1'b1);
			ntog <= ntog + (tog_o !== pin_q);
		end
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, wd};
		do @(posedge clk_sys_i); while (ack !== 1'b1);
		d = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk_sys_i);
	endtask : bus
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk($sformatf("reg %h", a), e, d);
	endtask : rchk
	task automatic pulse(input logic p, input logic [3:0] wd);
		{go, pin, width} <= {1'b1, p, wd};
		@(posedge clk_sys_i);
		go <= 0;
		repeat (12) @(posedge clk_sys_i);
	endtask : pulse
	initial begin
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 0;
		@(posedge clk_sys_i);
		bus(1, ADDR_COUNT_VALUE, 32'h1234);
		bus(1, 8'h20, 32'h55);
		for (i = 0; i < 9; i++) rchk(8'(4 * i), 0);
		for (i = 0; i < 3; i++) begin
			bus(1, ADDR_MODE_CTRL, 0);
			rchk(ADDR_COUNT_VALUE, 0);
			idle <= 0;
			bus(1, ADDR_PRESCALER, 32'({es[i], 4'h3}));
			bus(1, ADDR_CAPCMP_FIRST, 32'hff);
			bus(1, ADDR_MODE_CTRL, 32'hc);
			repeat (3) pulse(0, 4);
			idle <= 1;
			repeat (8) @(posedge clk_sys_i);
			rchk(ADDR_COUNT_VALUE, 32'(ec[i]));
		end
		bus(1, ADDR_MODE_CTRL, 0);
		idle <= 0;
		bus(1, ADDR_PRESCALER, 32'h13);
		bus(1, ADDR_CAPCMP_FIRST, 32'h2);
		bus(1, ADDR_CAPCMP_SECOND, 32'h1);
		bus(1, ADDR_OUT_CTRL, 32'h3);
		bus(1, ADDR_MODE_CTRL, 32'hc);
		{s1, s2, st} = {n1, n2, ntog};
		repeat (3) pulse(0, 4);
		pulse(0, 1);
		chk("irq_first", 0, 32'(n1 - s1));
		pulse(0, 4);
		chk("irq_first", 1, 32'(n1 - s1));
		repeat (3) pulse(0, 4);
		chk("irq_first", 2, 32'(n1 - s1));
		chk("irq_second", 2, 32'(n2 - s2));
		chk("toggles", 2, 32'(ntog - st));
		rchk(ADDR_COUNT_VALUE, 0);
		bus(1, ADDR_MODE_CTRL, 0);
		bus(1, ADDR_PRESCALER, 32'h50);
		bus(1, ADDR_CAPCMP_FIRST, 32'h10);
		bus(1, ADDR_CAPCMP_SECOND, 32'h20);
		bus(1, ADDR_OUT_CTRL, 32'h13);
		{s1, s2, st} = {n1, n2, ntog};
		bus(1, ADDR_MODE_CTRL, 32'h8);
		repeat (4) @(posedge clk_sys_i);
		bus(0, ADDR_COUNT_VALUE, 0);
		chk("running", 1, 32'(d != 0));
		// one full wrap plus the two compare points again
		repeat (65600) @(posedge clk_sys_i);
		chk("irq_first", 2, 32'(n1 - s1));
		chk("irq_second", 2, 32'(n2 - s2));
		chk("toggles", 4, 32'(ntog - st));
		rchk(ADDR_MODE_CTRL, 32'h9);
		bus(1, ADDR_MODE_CTRL, 32'h8);
		rchk(ADDR_MODE_CTRL, 32'h8);
		bus(1, ADDR_CAPCMP_CTRL, 32'h7);
		repeat (40) @(posedge clk_sys_i);
		{s1, s2, st} = {n1, n2, ntog};
		pulse(0, 8);
		chk("irq_second", 1, 32'(n2 - s2));
		chk("irq_first", 0, 32'(n1 - s1));
		bus(0, ADDR_CAPCMP_FIRST, 0);
		chk("phase_capture", 1, 32'(d != 0 && d < 32'h10));
		bus(0, ADDR_CAPCMP_SECOND, 0);
		chk("edge_capture", 1, 32'(d > 32'h10));
		pulse(1, 4);
		chk("irq_first", 1, 32'(n1 - s1));
		bus(1, ADDR_OUT_CTRL, 32'h8);
		chk("pin_disabled", 0, 32'(tog_o));
		rchk(ADDR_OUT_CTRL, 0);
		bus(1, ADDR_OUT_CTRL, 32'h1);
		chk("pin_level_set", 1, 32'(tog_o));
		bus(1, ADDR_OUT_CTRL, 32'h5);
		chk("pin_level_reset", 0, 32'(tog_o));
		bus(1, ADDR_MODE_CTRL, 32'ha);
		st = ntog;
		pulse(0, 4);
		chk("toggles", 1, 32'(ntog - st));
		chk("pin_clear_toggle", 1, 32'(tog_o));
		end_of_test();
	end
endmodule : ectc_top_tb_top
`default_nettype wire
